// file: design/vowc_consts.svh
`ifndef VOWC_CONSTS_SVH
`define VOWC_CONSTS_SVH

// Register indices; byte address is four times the index
`define VOWC_IDX_FLAG_POS 10'h10f
`define VOWC_IDX_VBEG 10'h120
`define VOWC_IDX_VLIN 10'h121
`define VOWC_IDX_VLOUT 10'h122
`define VOWC_IDX_HBEG 10'h123
`define VOWC_IDX_HLEN 10'h124
`define VOWC_IDX_NPIX 10'h125
`define VOWC_IDX_TDEC_CNT 10'h157

// Field positions
`define VOWC_TDEC_BIT 9
`define VOWC_FE_HI 11
`define VOWC_FE_LO 10

// Reset values
`define VOWC_RST_VBEG 9'h00c
`define VOWC_RST_VLIN 9'h000
`define VOWC_RST_VLOUT 9'h000
`define VOWC_RST_HBEG 11'h000
`define VOWC_RST_HLEN 11'h2c0
`define VOWC_RST_NPIX 11'h2c0
`define VOWC_RST_TDEC_CNT 12'h000

// Line standards and decimation interval
`define VOWC_LPF_625 9'h138
`define VOWC_LPF_525 9'h106
`define VOWC_FRAME_INTERVAL 12'hbb8

`endif

// file: design/vowc_pkg.sv
package vowc_pkg;

  typedef enum logic [1:0] {
    fe_both = 2'b00,
    fe_even = 2'b01,
    fe_odd = 2'b10,
    fe_off = 2'b11
  } vowc_fe_t;

endpackage : vowc_pkg

// file: design/vowc_dropper.sv
`timescale 1ns/100ps
module vowc_dropper
  import vowc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic restart,
  input wire logic step,
  input wire logic [11:0] total,
  input wire logic [11:0] wanted,
  // Decision for the current item
  output logic keep
);

  logic [12:0] acc_q, acc_d;
  logic keep_q, keep_d;
  logic [11:0] w_eff;
  logic [12:0] sum;

  // Spread kept items evenly, wanted out of every total
  always_comb begin
    w_eff = (wanted > total) ? total : wanted;
    sum = acc_q + {1'b0, w_eff};
    acc_d = acc_q;
    keep_d = keep_q;
    if (restart) begin
      acc_d = 13'h0000;
      keep_d = 1'b0;
    end else if (step) begin
      if (total != 12'h000 && sum >= {1'b0, total}) begin
        keep_d = 1'b1;
        acc_d = sum - {1'b0, total};
      end else begin
        keep_d = 1'b0;
        acc_d = sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_q <= 13'h0000;
      keep_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      keep_q <= keep_d;
    end
  end

  assign keep = keep_q;

  a_keep_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(keep_q) |-> $past(step) && !$past(restart))
    else $error("keep rose without a step");

endmodule : vowc_dropper

// file: design/vowc_window.sv
// How it works
// - Read-only bits 11..1 give active flag delay after reference trailing edge.
// - Nine-bit start line picks first active line of each field.
// - Start line is capped at one below the detected standard's line count.
// - Nine-bit input line count sets the window's line span.
// - Window end beyond the field's last line is clipped automatically.
// - With decimation on, only programmed frames per 3000 are output.
// - Field code 11 off, 10 odd only, 01 even only, 00 both.
// - Fewer output than input lines drops lines evenly.
// - Eleven-bit start pixel counts within the scaled active line.
// - Start pixel above zero crops pixels from the left.
// - Eleven-bit pixel count bounds the scaled active line.
`timescale 1ns/100ps
`include "vowc_consts.svh"
module vowc_window
  import vowc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [11:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [11:0] reg_rdata,
  // Video timing
  input wire logic field_start,
  input wire logic field_odd,
  input wire logic standard_525,
  input wire logic horizontal_reference,
  // Scaled pixel stream in
  input wire logic pixel_valid,
  input wire logic [15:0] pixel_in,
  // Windowed stream out
  output logic active_video,
  output logic [15:0] pixel_out
);

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [8:0] vbeg_q, vbeg_d;
  logic [8:0] vlin_q, vlin_d;
  logic tdec_q, tdec_d;
  vowc_fe_t fe_q, fe_d;
  logic [8:0] vlout_q, vlout_d;
  logic [10:0] hbeg_q, hbeg_d;
  logic [10:0] hlen_q, hlen_d;
  logic [10:0] npix_q, npix_d;
  logic [11:0] tcnt_q, tcnt_d;
  logic [11:0] rdata_q, rdata_d;
  logic [10:0] offset_q, offset_d;

  always_comb begin
    vbeg_d = vbeg_q;
    vlin_d = vlin_q;
    tdec_d = tdec_q;
    fe_d = fe_q;
    vlout_d = vlout_q;
    hbeg_d = hbeg_q;
    hlen_d = hlen_q;
    npix_d = npix_q;
    tcnt_d = tcnt_q;
    if (reg_write) begin
      if (hit(reg_addr, `VOWC_IDX_VBEG)) vbeg_d = reg_wdata[8:0];
      if (hit(reg_addr, `VOWC_IDX_VLIN)) begin
        vlin_d = reg_wdata[8:0];
        tdec_d = reg_wdata[`VOWC_TDEC_BIT];
        fe_d = vowc_fe_t'(reg_wdata[`VOWC_FE_HI:`VOWC_FE_LO]);
      end
      if (hit(reg_addr, `VOWC_IDX_VLOUT)) vlout_d = reg_wdata[8:0];
      if (hit(reg_addr, `VOWC_IDX_HBEG)) hbeg_d = reg_wdata[10:0];
      if (hit(reg_addr, `VOWC_IDX_HLEN)) hlen_d = reg_wdata[10:0];
      if (hit(reg_addr, `VOWC_IDX_NPIX)) npix_d = reg_wdata[10:0];
      if (hit(reg_addr, `VOWC_IDX_TDEC_CNT)) tcnt_d = reg_wdata;
    end
    rdata_d = 12'h000;
    if (reg_read) begin
      if (hit(reg_addr, `VOWC_IDX_FLAG_POS)) rdata_d = {offset_q, 1'b0};
      if (hit(reg_addr, `VOWC_IDX_VBEG)) rdata_d = {3'h0, vbeg_q};
      if (hit(reg_addr, `VOWC_IDX_VLIN)) rdata_d = {fe_q, tdec_q, vlin_q};
      if (hit(reg_addr, `VOWC_IDX_VLOUT)) rdata_d = {3'h0, vlout_q};
      if (hit(reg_addr, `VOWC_IDX_HBEG)) rdata_d = {1'b0, hbeg_q};
      if (hit(reg_addr, `VOWC_IDX_HLEN)) rdata_d = {1'b0, hlen_q};
      if (hit(reg_addr, `VOWC_IDX_NPIX)) rdata_d = {1'b0, npix_q};
      if (hit(reg_addr, `VOWC_IDX_TDEC_CNT)) rdata_d = tcnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      vbeg_q <= `VOWC_RST_VBEG;
      vlin_q <= `VOWC_RST_VLIN;
      tdec_q <= 1'b0;
      fe_q <= fe_both;
      vlout_q <= `VOWC_RST_VLOUT;
      hbeg_q <= `VOWC_RST_HBEG;
      hlen_q <= `VOWC_RST_HLEN;
      npix_q <= `VOWC_RST_NPIX;
      tcnt_q <= `VOWC_RST_TDEC_CNT;
      rdata_q <= 12'h000;
    end else begin
      vbeg_q <= vbeg_d;
      vlin_q <= vlin_d;
      tdec_q <= tdec_d;
      fe_q <= fe_d;
      vlout_q <= vlout_d;
      hbeg_q <= hbeg_d;
      hlen_q <= hlen_d;
      npix_q <= npix_d;
      tcnt_q <= tcnt_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Working copy, loaded only at field start
  logic [8:0] s_vbeg_q, s_vlin_q, s_vlout_q;
  logic s_tdec_q;
  vowc_fe_t s_fe_q;
  logic [10:0] s_hbeg_q, s_hlen_q, s_npix_q;
  logic [11:0] s_tcnt_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_vbeg_q <= `VOWC_RST_VBEG;
      s_vlin_q <= `VOWC_RST_VLIN;
      s_vlout_q <= `VOWC_RST_VLOUT;
      s_tdec_q <= 1'b0;
      s_fe_q <= fe_both;
      s_hbeg_q <= `VOWC_RST_HBEG;
      s_hlen_q <= `VOWC_RST_HLEN;
      s_npix_q <= `VOWC_RST_NPIX;
      s_tcnt_q <= `VOWC_RST_TDEC_CNT;
    end else if (field_start) begin
      s_vbeg_q <= vbeg_q;
      s_vlin_q <= vlin_q;
      s_vlout_q <= vlout_q;
      s_tdec_q <= tdec_q;
      s_fe_q <= fe_q;
      s_hbeg_q <= hbeg_q;
      s_hlen_q <= hlen_q;
      s_npix_q <= npix_q;
      s_tcnt_q <= tcnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vertical window
  logic [8:0] lpf, max_start, vbeg_eff, win_end, next_line;
  logic [9:0] end_sum;
  logic horizontal_reference_q, horizontal_reference_d, horizontal_reference_fall;
  logic [8:0] line_q, line_d;
  logic in_win_q, in_win_d, in_win_next;
  logic odd_q, odd_d;
  logic field_ok, line_keep, frame_keep, line_en;

  always_comb begin
    lpf = standard_525 ? `VOWC_LPF_525 : `VOWC_LPF_625;
    max_start = lpf - 9'h001;
    vbeg_eff = (s_vbeg_q > max_start) ? max_start : s_vbeg_q;
    end_sum = {1'b0, vbeg_eff} + {1'b0, s_vlin_q};
    win_end = (end_sum > {1'b0, lpf}) ? lpf : end_sum[8:0];
    horizontal_reference_fall = horizontal_reference_q && !horizontal_reference;
    next_line = (line_q == 9'h1ff) ? line_q : line_q + 9'h001;
    in_win_next = (next_line >= vbeg_eff) && (next_line < win_end);
    horizontal_reference_d = horizontal_reference;
    line_d = line_q;
    in_win_d = in_win_q;
    odd_d = odd_q;
    if (field_start) begin
      line_d = 9'h000;
      in_win_d = 1'b0;
      odd_d = field_odd;
    end else if (horizontal_reference_fall) begin
      line_d = next_line;
      in_win_d = in_win_next;
    end
    case (s_fe_q)
      fe_both: field_ok = 1'b1;
      fe_even: field_ok = !odd_q;
      fe_odd: field_ok = odd_q;
      fe_off: field_ok = 1'b0;
      default: field_ok = 1'b0;
    endcase
    line_en = in_win_q && line_keep && field_ok && (!s_tdec_q || frame_keep);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      horizontal_reference_q <= 1'b0;
      line_q <= 9'h000;
      in_win_q <= 1'b0;
      odd_q <= 1'b0;
    end else begin
      horizontal_reference_q <= horizontal_reference_d;
      line_q <= line_d;
      in_win_q <= in_win_d;
      odd_q <= odd_d;
    end
  end

  // Line dropping within a field
  vowc_dropper u_line_drop (
    .clk(clk),
    .reset(reset),
    .restart(field_start),
    .step(horizontal_reference_fall && !field_start && in_win_next),
    .total({3'h0, s_vlin_q}),
    .wanted({3'h0, s_vlout_q}),
    .keep(line_keep)
  );

  // Frame decimation, stepped once per frame
  vowc_dropper u_frame_drop (
    .clk(clk),
    .reset(reset),
    .restart(1'b0),
    .step(field_start && field_odd),
    .total(`VOWC_FRAME_INTERVAL),
    .wanted(s_tcnt_q),
    .keep(frame_keep)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Horizontal window and flag position
  logic [10:0] pix_q, pix_d, dly_q, dly_d, idx_q, idx_d;
  logic [11:0] h_end;
  logic hit_pix, seen_q, seen_d, act_q, act_d;
  logic [15:0] data_q, data_d;

  always_comb begin
    h_end = {1'b0, s_hbeg_q} + {1'b0, s_hlen_q};
    hit_pix = line_en && (pix_q >= s_hbeg_q) && ({1'b0, pix_q} < h_end)
      && (pix_q < s_npix_q);
    pix_d = pix_q;
    dly_d = (dly_q == 11'h7ff) ? dly_q : dly_q + 11'h001;
    seen_d = seen_q;
    offset_d = offset_q;
    if (horizontal_reference_fall) begin
      pix_d = 11'h000;
      dly_d = 11'h000;
      seen_d = 1'b0;
    end else if (pixel_valid) begin
      if (pix_q != 11'h7ff) pix_d = pix_q + 11'h001;
      if (hit_pix && !seen_q) begin
        offset_d = dly_q;
        seen_d = 1'b1;
      end
    end
    act_d = pixel_valid && hit_pix && !horizontal_reference_fall;
    data_d = pixel_valid ? pixel_in : data_q;
    idx_d = pix_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pix_q <= 11'h000;
      dly_q <= 11'h000;
      seen_q <= 1'b0;
      offset_q <= 11'h000;
      act_q <= 1'b0;
      data_q <= 16'h0000;
      idx_q <= 11'h000;
    end else begin
      pix_q <= pix_d;
      dly_q <= dly_d;
      seen_q <= seen_d;
      offset_q <= offset_d;
      act_q <= act_d;
      data_q <= data_d;
      idx_q <= idx_d;
    end
  end

  assign active_video = act_q;
  assign pixel_out = data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_first_pixel;
    pixel_valid && hit_pix && !seen_q && !horizontal_reference_fall;
  endsequence

  a_flag_delay: assert property (s_first_pixel |=> offset_q == $past(dly_q))
    else $error("flag position not captured");
  a_start_cap: assert property (vbeg_eff <= max_start)
    else $error("start line above standard limit");
  a_end_clip: assert property (win_end <= lpf)
    else $error("window end not clipped");
  a_field_off: assert property (s_fe_q == fe_off |=> !active_video)
    else $error("flag while window disabled");
  a_odd_only: assert property (s_fe_q == fe_odd && !odd_q |=> !active_video)
    else $error("flag in even field with odd only");
  a_left_crop: assert property (active_video |-> idx_q >= $past(s_hbeg_q))
    else $error("pixel left of start pixel flagged");
  a_length_end: assert property (active_video |-> {1'b0, idx_q} < $past(h_end))
    else $error("pixel beyond window length flagged");
  a_line_bound: assert property (active_video |-> idx_q < $past(s_npix_q))
    else $error("pixel beyond line pixel count flagged");
  a_cfg_hold: assert property (!field_start |=> $stable(s_vbeg_q) && $stable(s_hlen_q))
    else $error("window changed inside a field");
  a_drop_all: assert property (s_vlout_q == 9'h000 && !field_start |=> !line_keep)
    else $error("line kept with zero output lines");

endmodule : vowc_window

// file: verification/vowc_video_src.sv
`timescale 1ns/100ps
module vowc_video_src (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Field request
  input wire logic go,
  input wire logic odd,
  input wire logic [8:0] lines,
  input wire logic [7:0] npx,
  output logic busy,
  // Timing and pixels out
  output logic field_start,
  output logic field_odd,
  output logic horizontal_reference,
  output logic pixel_valid,
  output logic [15:0] pixel_in,
  // Windowed stream back
  input wire logic active_video,
  input wire logic [15:0] pixel_out,
  output logic [15:0] n_active,
  output logic [15:0] first_px
);
  logic [7:0] ln;

  ////////////////////////////////////////
  // Reference falls two cycles ahead of pixels
  initial begin
    busy = 1'b0;
    field_start = 1'b0;
    field_odd = 1'b0;
    horizontal_reference = 1'b1;
    pixel_valid = 1'b0;
    pixel_in = 16'h0000;
    forever begin
      @(posedge clk);
      if (go === 1'b1 && reset === 1'b0) begin
        busy <= 1'b1;
        field_odd <= odd;
        field_start <= 1'b1;
        @(posedge clk);
        field_start <= 1'b0;
        for (int l = 0; l < int'(lines); l++) begin
          ln = 8'(l + 1);
          horizontal_reference <= 1'b1;
          repeat (2) @(posedge clk);
          horizontal_reference <= 1'b0;
          repeat (2) @(posedge clk);
          for (int p = 0; p < int'(npx); p++) begin
            pixel_valid <= 1'b1;
            pixel_in <= {ln, p[7:0]};
            @(posedge clk);
          end
          pixel_valid <= 1'b0;
          // Idle data differs from the last pixel
          pixel_in <= ~pixel_in;
        end
        horizontal_reference <= 1'b1;
        repeat (4) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////
  // Count flagged pixels per field
  always @(posedge clk) begin
    if (reset || field_start) begin
      n_active <= 16'h0000;
      first_px <= 16'hffff;
    end else if (active_video === 1'b1) begin
      n_active <= n_active + 16'h0001;
      if (n_active == 16'h0000) begin
        first_px <= pixel_out;
      end
    end
  end
endmodule : vowc_video_src

// file: verification/tb_vowc_window.sv
`timescale 1ns/100ps
`include "vowc_consts.svh"
module tb_vowc_window;
  import vowc_pkg::*;
  logic clk, reset, reg_write, reg_read, standard_525, go, odd, busy;
  logic [11:0] reg_addr, reg_wdata, reg_rdata;
  logic field_start, field_odd, horizontal_reference, pixel_valid, active_video;
  logic [15:0] pixel_in, pixel_out, n_active, first_px, sum;
  logic [8:0] lines;
  logic [7:0] npx;
  vowc_fe_t fe;
  logic [9:0] idx_tab [6] = '{`VOWC_IDX_VBEG, `VOWC_IDX_VLIN, `VOWC_IDX_VLOUT, `VOWC_IDX_HBEG,
    `VOWC_IDX_HLEN, `VOWC_IDX_NPIX};
  logic [11:0] rst_tab [6] = '{12'h00c, 12'h000, 12'h000, 12'h000, 12'h2c0, 12'h2c0};
  int n_errors = 0;
  int comparisons = 0;

  vowc_window u_vowc_window (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .field_start(field_start),
    .field_odd(field_odd), .standard_525(standard_525), .horizontal_reference(horizontal_reference),
    .pixel_valid(pixel_valid), .pixel_in(pixel_in), .active_video(active_video), .pixel_out(pixel_out));
  vowc_video_src u_vowc_video_src (.clk(clk), .reset(reset), .go(go), .odd(odd), .lines(lines),
    .npx(npx), .busy(busy), .field_start(field_start), .field_odd(field_odd),
    .horizontal_reference(horizontal_reference), .pixel_valid(pixel_valid), .pixel_in(pixel_in),
    .active_video(active_video), .pixel_out(pixel_out), .n_active(n_active), .first_px(first_px));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [9:0] idx, input logic [11:0] d);
    reg_addr <= {idx, 2'b00};
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd_chk(input string what, input logic [9:0] idx, input logic [11:0] exp);
    reg_addr <= {idx, 2'b00};
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(what, {4'h0, reg_rdata}, {4'h0, exp});
    @(posedge clk);
  endtask : rd_chk

  task automatic cfg(input logic [8:0] vb, input logic [11:0] vl, input logic [8:0] vo,
    input logic [10:0] hb, input logic [10:0] hl, input logic [10:0] np);
    wr(`VOWC_IDX_VBEG, {3'b000, vb});
    wr(`VOWC_IDX_VLIN, vl);
    wr(`VOWC_IDX_VLOUT, {3'b000, vo});
    wr(`VOWC_IDX_HBEG, {1'b0, hb});
    wr(`VOWC_IDX_HLEN, {1'b0, hl});
    wr(`VOWC_IDX_NPIX, {1'b0, np});
  endtask : cfg

  task automatic field(input logic o, input logic [8:0] nl, input logic [7:0] np);
    odd <= o;
    lines <= nl;
    npx <= np;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    do @(negedge clk); while (busy === 1'b1);
    @(posedge clk);
  endtask : field

  task automatic close_out;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////
  initial begin
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 12'h000;
    standard_525 = 1'b0;
    go = 1'b0;
    odd = 1'b0;
    lines = 9'h000;
    npx = 8'h00;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk("reset value", idx_tab[i], rst_tab[i]);
    wr(`VOWC_IDX_FLAG_POS, 12'hffe);
    rd_chk("flag position", `VOWC_IDX_FLAG_POS, 12'h000);
    wr(10'h126, 12'h555);
    rd_chk("unmapped", 10'h126, 12'h000);
    $display("test registers done");
    cfg(9'h00c, 12'h008, 9'h008, 11'h002, 11'h005, 11'h020);
    rd_chk("length", `VOWC_IDX_HLEN, 12'h005);
    field(1'b1, 9'h028, 8'h0a);
    check("window pixels", n_active, 16'h0028);
    check("first pixel", first_px, 16'h0c02);
    rd_chk("flag position", `VOWC_IDX_FLAG_POS, 12'h006);
    wr(`VOWC_IDX_VLOUT, 12'h004);
    field(1'b1, 9'h028, 8'h0a);
    check("dropped lines", n_active, 16'h0014);
    $display("test window done");
    for (int f = 0; f < 4; f++) begin
      for (int o = 0; o < 2; o++) begin
        fe = vowc_fe_t'(f[1:0]);
        wr(`VOWC_IDX_VLIN, {f[1:0], 10'h008});
        field(o[0], 9'h028, 8'h0a);
        sum = (fe == fe_both || (fe == fe_odd && o == 1) || (fe == fe_even && o == 0)) ? 16'h0014 : 16'h0000;
        check("field code", n_active, sum);
      end
    end
    $display("test field codes done");
    standard_525 <= 1'b1;
    cfg(9'h0ff, 12'h014, 9'h014, 11'h000, 11'h004, 11'h020);
    field(1'b1, 9'h108, 8'h04);
    check("clip 525", n_active, 16'h001c);
    wr(`VOWC_IDX_VBEG, 12'h12c);
    field(1'b1, 9'h108, 8'h04);
    check("start cap 525", n_active, 16'h0004);
    standard_525 <= 1'b0;
    field(1'b1, 9'h140, 8'h04);
    check("clip 625", n_active, 16'h0030);
    $display("test clipping done");
    cfg(9'h00c, 12'h208, 9'h008, 11'h000, 11'h004, 11'h020);
    field(1'b1, 9'h028, 8'h04);
    check("count zero", n_active, 16'h0000);
    wr(`VOWC_IDX_TDEC_CNT, 12'h5dc);
    field(1'b1, 9'h028, 8'h04);
    sum = 16'h0000;
    repeat (4) begin
      field(1'b1, 9'h028, 8'h04);
      sum = sum + n_active;
    end
    check("decimated", sum, 16'h0040);
    $display("test decimation done");
    close_out();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("[FAIL] watchdog expected end seen timeout");
    close_out();
  end
endmodule : tb_vowc_window
